// ==== pkg/tmr2_defines.vh ====
`ifndef TMR2_DEFINES_VH
`define TMR2_DEFINES_VH
// register addresses
`define TMR2_ADDR_MODE_EXT 8'h93
`define TMR2_ADDR_PIN_SEL 8'hA4
`define TMR2_ADDR_CONTROL 8'hC8
`define TMR2_ADDR_MODE 8'hC9
`define TMR2_ADDR_RELOAD_LOW 8'hCA
`define TMR2_ADDR_RELOAD_HIGH 8'hCB
`define TMR2_ADDR_COUNT_LOW 8'hCC
`define TMR2_ADDR_COUNT_HIGH 8'hCD
`define TMR2_RESET_VALUE 8'h00
// control register bits
`define TMR2_CON_FULL_OVF 7
`define TMR2_CON_EXT_FLAG 6
`define TMR2_CON_ALIAS5 5
`define TMR2_CON_ALIAS4 4
`define TMR2_CON_FALL_EN 3
`define TMR2_CON_MAIN_RUN 2
`define TMR2_CON_COUNTER_SEL 1
`define TMR2_CON_CAP_RELOAD 0
// mode register bits
`define TMR2_MOD_SPLIT 7
`define TMR2_MOD_ALIAS6 6
`define TMR2_MOD_RISE_EN 5
`define TMR2_MOD_PRESCALE 4
`define TMR2_MOD_LOW_RUN 3
`define TMR2_MOD_AUTO_STOP 2
`define TMR2_MOD_CLKOUT_EN 1
`define TMR2_MOD_BIT0 0
// extended mode register bits
`define TMR2_EXT_LOW_GROUP 7
`define TMR2_EXT_IRQ_IGNORE 6
`define TMR2_EXT_BANK_SEL 5
`define TMR2_EXT_CLK_GROUP 4
`define TMR2_EXT_MODE_BIT1 3
// mode codes
`define TMR2_MODE_RELOAD0 3'h0
`define TMR2_MODE_RELOAD1 3'h1
`define TMR2_MODE_CAPTURE 3'h2
`define TMR2_MODE_CAP_ZERO 3'h3
`define TMR2_MODE_PWM8 3'h4
`define TMR2_MODE_DUTY 3'h6
// prescale divider
`define TMR2_DIV12 4'hB
`endif

// ==== logic/tmr2_edge_sync.v ====
`timescale 1ns/100ps
// two-flop synchroniser with rise and fall pulses, one per input bit
module tmr2_edge_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// levels
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut,
	// pulses
	output wire [WIDTH-1:0] risePulse,
	output wire [WIDTH-1:0] fallPulse
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
			stage3_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	assign syncOut = stage2_reg;
	assign risePulse = stage2_reg & ~stage3_reg;
	assign fallPulse = ~stage2_reg & stage3_reg;
endmodule // tmr2_edge_sync

// ==== logic/tmr2_core.v ====
`timescale 1ns/100ps
`include "tmr2_defines.vh"
module tmr2_core (
	// clock and reset
	input wire clock,
	input wire rst_n,
	// special function register port
	input wire [7:0] sfrAddr,
	input wire [1:0] sfrPage,
	input wire sfrWrite,
	input wire [7:0] sfrWdata,
	output reg [7:0] sfrRdata,
	// event sources
	input wire extInt0Event,
	input wire extInt1Event,
	input wire baudGenOverflow,
	input wire timer0Overflow,
	input wire comparatorEvent,
	input wire comparatorOutput,
	input wire keypadEvent,
	input wire lowSpeedRcOsc,
	input wire serial0Receive,
	input wire twoWire0ClockLine,
	// port pins, inputs
	input wire p30In,
	input wire p31In,
	input wire p33In,
	input wire p44In,
	input wire p45In,
	input wire p46In,
	// clock-out pin, one output and enable per candidate pin
	output reg [3:0] clockOutData,
	output reg [3:0] clockOutOe,
	// interrupt requests and serial clocks
	output wire timer2Irq,
	output wire serialRxClock,
	output wire serialTxClock
);
	reg [7:0] controlReg_reg;
	reg [7:0] modeReg_reg;
	reg [7:0] modeExt_reg;
	reg [7:0] pinSel_reg;
	reg [7:0] reloadLow_reg;
	reg [7:0] reloadHigh_reg;
	reg [7:0] countLow_reg;
	reg [7:0] countHigh_reg;
	reg lowOverflowFlag_reg;
	reg lowIrqEnable_reg;
	reg lowPrescale_reg;
	reg triggerInvert_reg;
	reg [3:0] div12_reg;
	reg clockOutLevel_reg;

	// pin and event synchronisation
	wire [15:0] rawIn;
	wire [15:0] syncLevel;
	wire [15:0] rise;
	wire [15:0] fall;
	assign rawIn = {twoWire0ClockLine, serial0Receive, lowSpeedRcOsc, keypadEvent,
		comparatorOutput, comparatorEvent, timer0Overflow, baudGenOverflow,
		extInt1Event, extInt0Event, p46In, p45In, p44In, p33In, p31In, p30In};
	tmr2_edge_sync #(.WIDTH(16)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.asyncIn(rawIn),
		.syncOut(syncLevel),
		.risePulse(rise),
		.fallPulse(fall)
	);
	wire int0Ev = rise[6];
	wire int1Ev = rise[7];
	wire baudEv = rise[8];
	wire t0Ev = rise[9];
	wire compEv = rise[10];
	wire keyEv = rise[12];

	// fields
	wire splitOn = modeReg_reg[`TMR2_MOD_SPLIT];
	wire mainRun = controlReg_reg[`TMR2_CON_MAIN_RUN];
	wire lowRun = modeReg_reg[`TMR2_MOD_LOW_RUN];
	wire rxClockSel = controlReg_reg[`TMR2_CON_ALIAS5];
	wire txClockSel = controlReg_reg[`TMR2_CON_ALIAS4];
	wire serialClocking = rxClockSel | txClockSel;
	wire [2:0] clockCode = {modeExt_reg[`TMR2_EXT_CLK_GROUP], modeReg_reg[`TMR2_MOD_PRESCALE],
		controlReg_reg[`TMR2_CON_COUNTER_SEL]};
	wire [2:0] modeCode = {modeExt_reg[`TMR2_EXT_MODE_BIT1],
		controlReg_reg[`TMR2_CON_CAP_RELOAD], modeReg_reg[`TMR2_MOD_BIT0]};
	wire [1:0] routeSel = pinSel_reg[7:6];

	// one-hot decode of a 2-bit select, used for pin routing
	function [3:0] dec4;
		input [1:0] sel;
		begin
			dec4 = 4'h1 << sel;
		end
	endfunction

	// port routing of count pin and trigger pin
	reg countPinRise;
	reg trigRaw;
	always @* begin
		case (routeSel)
			2'h0: begin
				countPinRise = fall[1];
				trigRaw = syncLevel[0];
			end
			2'h1: begin
				countPinRise = fall[2];
				trigRaw = syncLevel[5];
			end
			2'h2: begin
				countPinRise = fall[5];
				trigRaw = syncLevel[2];
			end
			default: begin
				countPinRise = fall[4];
				trigRaw = syncLevel[3];
			end
		endcase
	end

	// inversion precedes edge detection
	wire trigLevel = trigRaw ^ triggerInvert_reg;
	reg trigLevelDly_reg;
	wire trigRise = trigLevel & ~trigLevelDly_reg;
	wire trigFall = ~trigLevel & trigLevelDly_reg;
	wire trigEdge = (trigRise & modeReg_reg[`TMR2_MOD_RISE_EN]) |
		(trigFall & controlReg_reg[`TMR2_CON_FALL_EN]);

	// capture source selector
	reg capSrcEv;
	always @* begin
		case (modeExt_reg[2:0])
			3'h0: capSrcEv = trigEdge;
			3'h1: capSrcEv = fall[14];
			3'h2: capSrcEv = fall[4];
			3'h3: capSrcEv = int1Ev;
			3'h4: capSrcEv = rise[13];
			3'h5: capSrcEv = rise[11];
			3'h6: capSrcEv = keyEv;
			default: capSrcEv = fall[15];
		endcase
	end

	// prescaler: divide by 12 tick
	wire div12Tick = (div12_reg == `TMR2_DIV12);

	// low-byte clock source
	reg lowTick;
	always @* begin
		case ({modeExt_reg[`TMR2_EXT_LOW_GROUP], lowPrescale_reg})
			2'h0: lowTick = div12Tick;
			2'h1: lowTick = 1'b1;
			2'h2: lowTick = baudEv;
			default: lowTick = int0Ev;
		endcase
	end

	wire lowCountEn = splitOn & lowRun & lowTick;
	wire lowOverflow = lowCountEn & (countLow_reg == 8'hFF);

	// full and high byte clock source
	reg fullTick;
	always @* begin
		case (clockCode)
			3'h0: fullTick = div12Tick;
			3'h1: fullTick = countPinRise;
			3'h2: fullTick = 1'b1;
			3'h3: fullTick = splitOn ? lowOverflow : int0Ev;
			3'h4: fullTick = baudEv;
			3'h5: fullTick = t0Ev;
			3'h6: fullTick = compEv;
			default: fullTick = keyEv;
		endcase
	end

	// counting: split halves have no carry
	wire highCountEn = mainRun & fullTick;
	wire fullOverflow = ~splitOn & highCountEn & ({countHigh_reg, countLow_reg} == 16'hFFFF);
	wire highOverflow = splitOn ? (highCountEn & (countHigh_reg == 8'hFF)) : fullOverflow;

	// mode decode
	wire isReload = (modeCode == `TMR2_MODE_RELOAD0) | (modeCode == `TMR2_MODE_RELOAD1);
	wire isCapture = (modeCode == `TMR2_MODE_CAPTURE) | (modeCode == `TMR2_MODE_CAP_ZERO);
	wire isAutoZero = (modeCode == `TMR2_MODE_CAP_ZERO);
	wire isPwm = splitOn & (modeCode == `TMR2_MODE_PWM8);
	// duty capture is reserved in split mode, so it is honoured only when unsplit
	wire isDuty = ~splitOn & (modeCode == `TMR2_MODE_DUTY);
	reg dutyPhase_reg;

	// capture/reload action, suppressed while clocking serial port
	wire extAction = capSrcEv & ~serialClocking;
	wire flagEvent = trigEdge;
	wire capEvent = extAction & (isCapture | isDuty);
	wire reloadByEdge = extAction & isReload & (modeCode == `TMR2_MODE_RELOAD1);

	// auto-stop trigger
	wire autoStop = modeReg_reg[`TMR2_MOD_AUTO_STOP] &
		((isReload & highOverflow) | (isCapture & capEvent));

	// register writes, bank aliasing
	wire wrCon = sfrWrite & (sfrPage == 2'h0) & (sfrAddr == `TMR2_ADDR_CONTROL);
	wire wrMod = sfrWrite & (sfrPage == 2'h0) & (sfrAddr == `TMR2_ADDR_MODE);
	wire wrExt = sfrWrite & (sfrPage == 2'h1) & (sfrAddr == `TMR2_ADDR_MODE_EXT);
	wire wrPin = sfrWrite & (sfrPage == 2'h1) & (sfrAddr == `TMR2_ADDR_PIN_SEL);
	wire wrRl = sfrWrite & (sfrPage == 2'h0) & (sfrAddr == `TMR2_ADDR_RELOAD_LOW);
	wire wrRh = sfrWrite & (sfrPage == 2'h0) & (sfrAddr == `TMR2_ADDR_RELOAD_HIGH);
	wire wrTl = sfrWrite & (sfrPage == 2'h0) & (sfrAddr == `TMR2_ADDR_COUNT_LOW);
	wire wrTh = sfrWrite & (sfrPage == 2'h0) & (sfrAddr == `TMR2_ADDR_COUNT_HIGH);
	wire bankSel = modeExt_reg[`TMR2_EXT_BANK_SEL];

	reg [7:0] control_next;
	reg [7:0] mode_next;
	reg [7:0] countLow_next;
	reg [7:0] countHigh_next;
	reg [7:0] reloadLow_next;
	reg [7:0] reloadHigh_next;
	always @* begin
		control_next = controlReg_reg;
		mode_next = modeReg_reg;
		countLow_next = countLow_reg;
		countHigh_next = countHigh_reg;
		reloadLow_next = reloadLow_reg;
		reloadHigh_next = reloadHigh_reg;
		if (wrCon) begin
			control_next[7:6] = sfrWdata[7:6];
			control_next[3:0] = sfrWdata[3:0];
			if (!bankSel) begin
				control_next[5:4] = sfrWdata[5:4];
			end
		end
		if (wrMod) begin
			mode_next[7] = sfrWdata[7];
			mode_next[5:0] = sfrWdata[5:0];
		end
		if (wrRl) begin
			reloadLow_next = sfrWdata;
		end
		if (wrRh) begin
			reloadHigh_next = sfrWdata;
		end
		if (wrTl) begin
			countLow_next = sfrWdata;
		end
		if (wrTh) begin
			countHigh_next = sfrWdata;
		end
		// hardware sets win over software clears
		if (fullOverflow & ~serialClocking) begin
			control_next[`TMR2_CON_FULL_OVF] = 1'b1;
		end
		if (flagEvent) begin
			control_next[`TMR2_CON_EXT_FLAG] = 1'b1;
		end
		if (autoStop) begin
			mode_next[`TMR2_MOD_LOW_RUN] = 1'b0;
		end
		// counting
		if (splitOn) begin
			if (lowCountEn) begin
				countLow_next = lowOverflow ? reloadLow_reg : countLow_reg + 8'h01;
			end
			if (highCountEn) begin
				countHigh_next = (countHigh_reg == 8'hFF) ? reloadHigh_reg :
					countHigh_reg + 8'h01;
			end
		end else if (highCountEn) begin
			if (fullOverflow & (isReload | isPwm)) begin
				countLow_next = reloadLow_reg;
				countHigh_next = reloadHigh_reg;
			end else begin
				{countHigh_next, countLow_next} = {countHigh_reg, countLow_reg} + 16'h0001;
			end
		end
		if (reloadByEdge) begin
			countLow_next = reloadLow_reg;
			countHigh_next = reloadHigh_reg;
		end
		if (capEvent) begin
			reloadLow_next = countLow_reg;
			reloadHigh_next = countHigh_reg;
			if (isAutoZero | (isDuty & dutyPhase_reg)) begin
				countLow_next = 8'h00;
				countHigh_next = 8'h00;
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			controlReg_reg <= `TMR2_RESET_VALUE;
			modeReg_reg <= `TMR2_RESET_VALUE;
			modeExt_reg <= `TMR2_RESET_VALUE;
			pinSel_reg <= `TMR2_RESET_VALUE;
			reloadLow_reg <= `TMR2_RESET_VALUE;
			reloadHigh_reg <= `TMR2_RESET_VALUE;
			countLow_reg <= `TMR2_RESET_VALUE;
			countHigh_reg <= `TMR2_RESET_VALUE;
			lowOverflowFlag_reg <= 1'b0;
			lowIrqEnable_reg <= 1'b0;
			lowPrescale_reg <= 1'b0;
			triggerInvert_reg <= 1'b0;
			div12_reg <= 4'h0;
			clockOutLevel_reg <= 1'b0;
			trigLevelDly_reg <= 1'b0;
			dutyPhase_reg <= 1'b0;
		end else begin
			controlReg_reg <= control_next;
			modeReg_reg <= mode_next;
			reloadLow_reg <= reloadLow_next;
			reloadHigh_reg <= reloadHigh_next;
			countLow_reg <= countLow_next;
			countHigh_reg <= countHigh_next;
			div12_reg <= div12Tick ? 4'h0 : div12_reg + 4'h1;
			trigLevelDly_reg <= trigLevel;
			if (wrExt) begin
				modeExt_reg <= sfrWdata;
			end
			if (wrPin) begin
				pinSel_reg <= {sfrWdata[7:6], 6'h00};
			end
			// aliased bits reached through the bank select
			if (wrMod) begin
				if (bankSel) begin
					triggerInvert_reg <= sfrWdata[`TMR2_MOD_ALIAS6];
				end else begin
					lowPrescale_reg <= sfrWdata[`TMR2_MOD_ALIAS6];
				end
			end
			if (wrCon & bankSel) begin
				lowIrqEnable_reg <= sfrWdata[`TMR2_CON_ALIAS4];
			end
			if (lowOverflow) begin
				lowOverflowFlag_reg <= 1'b1;
			end else if (wrCon & bankSel) begin
				lowOverflowFlag_reg <= sfrWdata[`TMR2_CON_ALIAS5];
			end
			if (capEvent & isDuty) begin
				dutyPhase_reg <= ~dutyPhase_reg;
			end
			// clock-out toggles on the overflow that paces it
			if (splitOn ? lowOverflow : fullOverflow) begin
				clockOutLevel_reg <= ~clockOutLevel_reg;
			end else if (isPwm & lowCountEn) begin
				clockOutLevel_reg <= (countLow_reg + 8'h01) < reloadHigh_reg;
			end
		end
	end

	// clock-out pin drive
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clockOutData <= 4'h0;
			clockOutOe <= 4'h0;
		end else begin
			clockOutData <= {4{clockOutLevel_reg}};
			clockOutOe <= modeReg_reg[`TMR2_MOD_CLKOUT_EN] ? dec4(routeSel) : 4'h0;
		end
	end

	// interrupt: ignore bit gates the full overflow request
	assign timer2Irq = (controlReg_reg[`TMR2_CON_FULL_OVF] & ~modeExt_reg[`TMR2_EXT_IRQ_IGNORE]) |
		controlReg_reg[`TMR2_CON_EXT_FLAG] | (lowOverflowFlag_reg & lowIrqEnable_reg);
	assign serialRxClock = rxClockSel & highOverflow;
	assign serialTxClock = txClockSel & highOverflow;

	// read mux, aliased views follow the bank select
	always @* begin
		sfrRdata = 8'h00;
		if (sfrPage == 2'h0) begin
			case (sfrAddr)
				`TMR2_ADDR_CONTROL: sfrRdata = bankSel ?
					{controlReg_reg[7:6], lowOverflowFlag_reg, lowIrqEnable_reg,
					controlReg_reg[3:0]} : controlReg_reg;
				`TMR2_ADDR_MODE: sfrRdata = {modeReg_reg[7],
					bankSel ? triggerInvert_reg : lowPrescale_reg, modeReg_reg[5:0]};
				`TMR2_ADDR_RELOAD_LOW: sfrRdata = reloadLow_reg;
				`TMR2_ADDR_RELOAD_HIGH: sfrRdata = reloadHigh_reg;
				`TMR2_ADDR_COUNT_LOW: sfrRdata = countLow_reg;
				`TMR2_ADDR_COUNT_HIGH: sfrRdata = countHigh_reg;
				default: sfrRdata = 8'h00;
			endcase
		end else if (sfrPage == 2'h1) begin
			case (sfrAddr)
				`TMR2_ADDR_MODE_EXT: sfrRdata = modeExt_reg;
				`TMR2_ADDR_PIN_SEL: sfrRdata = pinSel_reg;
				default: sfrRdata = 8'h00;
			endcase
		end
	end
endmodule // tmr2_core

// ==== sim/tmr2_core_checker.sv ====
`timescale 1ns/100ps
`include "tmr2_defines.vh"
module tmr2_core_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] sfrAddr,
	input wire logic [1:0] sfrPage,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	// outputs watched
	input wire logic [3:0] clockOutOe,
	input wire logic serialRxClock,
	input wire logic serialTxClock
);
	// shadows of bits that hardware never changes
	logic coeSh;
	logic runSh;
	logic [1:0] routeSh;
	logic [1:0] serSh;
	logic bankSh;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			coeSh <= 1'b0;
			runSh <= 1'b0;
			routeSh <= 2'h0;
			serSh <= 2'h0;
			bankSh <= 1'b0;
		end else if (sfrWrite) begin
			if (sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_MODE)
				coeSh <= sfrWdata[1];
			if (sfrPage == 2'h1 && sfrAddr == `TMR2_ADDR_MODE_EXT)
				bankSh <= sfrWdata[5];
			if (sfrPage == 2'h1 && sfrAddr == `TMR2_ADDR_PIN_SEL)
				routeSh <= sfrWdata[7:6];
			if (sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_CONTROL) begin
				runSh <= sfrWdata[2];
				if (!bankSh)
					serSh <= sfrWdata[5:4];
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_oe_off;
		!coeSh && !$past(coeSh) |-> clockOutOe == 4'h0;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("clock-out enable driven while off");
	property p_oe_route;
		coeSh && $past(coeSh) && routeSh == $past(routeSh) |-> clockOutOe == (4'h1 << routeSh);
	endproperty
	a_oe_route: assert property (p_oe_route) else $error("clock-out pin not routed");
	property p_pin_zero;
		sfrPage == 2'h1 && sfrAddr == `TMR2_ADDR_PIN_SEL |-> sfrRdata[5:0] == 6'h00;
	endproperty
	a_pin_zero: assert property (p_pin_zero) else $error("pin select low bits not zero");
	property p_rld_low;
		sfrWrite && sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_RELOAD_LOW ##1
		sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_RELOAD_LOW |-> sfrRdata == $past(sfrWdata);
	endproperty
	a_rld_low: assert property (p_rld_low) else $error("reload low readback");
	property p_rld_high;
		sfrWrite && sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_RELOAD_HIGH ##1
		sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_RELOAD_HIGH |-> sfrRdata == $past(sfrWdata);
	endproperty
	a_rld_high: assert property (p_rld_high) else $error("reload high readback");
	property p_cnt_high;
		!runSh && sfrWrite && sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_COUNT_HIGH ##1
		sfrPage == 2'h0 && sfrAddr == `TMR2_ADDR_COUNT_HIGH |-> sfrRdata == $past(sfrWdata);
	endproperty
	a_cnt_high: assert property (p_cnt_high) else $error("stopped count high readback");
	property p_tx_quiet;
		!serSh[0] && !$past(serSh[0]) && !$past(serSh[0], 2) |-> !serialTxClock;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet) else $error("transmit clock while deselected");
	property p_rx_quiet;
		!serSh[1] && !$past(serSh[1]) && !$past(serSh[1], 2) |-> !serialRxClock;
	endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("receive clock while deselected");
	property p_first;
		$rose(rst_n) |-> sfrRdata == 8'h00;
	endproperty
	a_first: assert property (p_first) else $error("register not zero after reset");
endmodule // tmr2_core_checker
bind tmr2_core tmr2_core_checker u_chk (.clock(clock), .rst_n(rst_n), .sfrAddr(sfrAddr),
	.sfrPage(sfrPage), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
	.clockOutOe(clockOutOe), .serialRxClock(serialRxClock), .serialTxClock(serialTxClock));

// ==== sim/tmr2_core_test.sv ====
`timescale 1ns/100ps
`include "tmr2_defines.vh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module tmr2_core_test;
	logic clock, rst_n, sfrWrite;
	logic [1:0] sfrPage;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata, v, w;
	logic [9:0] ev;
	logic [5:0] pin;
	logic [3:0] clockOutData, clockOutOe;
	logic timer2Irq, serialRxClock, serialTxClock;
	int n_mismatch, checks_done, cycles;
	int txPulses;
	tmr2_core u_dut (.clock(clock), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
		.sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.extInt0Event(ev[0]), .extInt1Event(ev[1]), .baudGenOverflow(ev[2]),
		.timer0Overflow(ev[3]), .comparatorEvent(ev[4]), .comparatorOutput(ev[5]),
		.keypadEvent(ev[6]), .lowSpeedRcOsc(ev[7]), .serial0Receive(ev[8]),
		.twoWire0ClockLine(ev[9]), .p30In(pin[0]), .p31In(pin[1]), .p33In(pin[2]),
		.p44In(pin[3]), .p45In(pin[4]), .p46In(pin[5]), .clockOutData(clockOutData),
		.clockOutOe(clockOutOe), .timer2Irq(timer2Irq), .serialRxClock(serialRxClock),
		.serialTxClock(serialTxClock));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfrPage = p;
		sfrAddr = a;
		sfrWdata = d;
		sfrWrite = 1'b1;
		@(negedge clock);
		sfrWrite = 1'b0;
	endtask
	task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfrPage = p;
		sfrAddr = a;
		#1 d = sfrRdata;
	endtask
	task automatic stop_test;
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// serial clock pulses last one cycle, so the falling edge sees each one
	always @(negedge clock) begin
		if (serialTxClock === 1'b1)
			txPulses++;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic t_reset;
		logic [8:0] tbl [8] = '{9'h0C8, 9'h0C9, 9'h0CA, 9'h0CB, 9'h0CC, 9'h0CD, 9'h193, 9'h1A4};
		for (int i = 0; i < 8; i++) begin
			rd({1'b0, tbl[i][8]}, tbl[i][7:0], v);
			`CHK(v, `TMR2_RESET_VALUE)
		end
	endtask
	task automatic t_regs;
		logic [7:0] tbl [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
		for (int i = 0; i < 4; i++) begin
			wr(2'h0, `TMR2_ADDR_RELOAD_LOW + i[7:0], tbl[i]);
			rd(2'h0, `TMR2_ADDR_RELOAD_LOW + i[7:0], v);
			`CHK(v, tbl[i])
		end
		rd(2'h0, 8'h00, v);
		`CHK(v, 8'h00)
		rd(2'h1, `TMR2_ADDR_MODE, v);
		`CHK(v, 8'h00)
	endtask
	task automatic t_alias;
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h30);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h40);
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h20);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[5:4], 2'b00)
		rd(2'h0, `TMR2_ADDR_MODE, v);
		`CHK(v[6], 1'b0)
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h00);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v, 8'h30)
		rd(2'h0, `TMR2_ADDR_MODE, v);
		`CHK(v, 8'h40)
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h00);
	endtask
	task automatic t_count;
		int n;
		wr(2'h0, `TMR2_ADDR_COUNT_LOW, 8'h34);
		wr(2'h0, `TMR2_ADDR_COUNT_HIGH, 8'h12);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h10);
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h04);
		repeat (100) @(negedge clock);
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h00);
		rd(2'h0, `TMR2_ADDR_COUNT_LOW, v);
		rd(2'h0, `TMR2_ADDR_COUNT_HIGH, w);
		`CHK({w, v} >= 16'h1297 && {w, v} <= 16'h129C, 1'b1)
		wr(2'h0, `TMR2_ADDR_RELOAD_HIGH, 8'hAB);
		wr(2'h0, `TMR2_ADDR_COUNT_LOW, 8'hF8);
		wr(2'h0, `TMR2_ADDR_COUNT_HIGH, 8'hFF);
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h04);
		repeat (20) @(negedge clock);
		`CHK(timer2Irq, 1'b1)
		`CHK(clockOutData, 4'hF)
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h40);
		repeat (2) @(negedge clock);
		`CHK(timer2Irq, 1'b0)
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h00);
		rd(2'h0, `TMR2_ADDR_COUNT_HIGH, v);
		`CHK(v, 8'hAB)
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h00);
		wr(2'h0, `TMR2_ADDR_COUNT_HIGH, 8'hFF);
		wr(2'h0, `TMR2_ADDR_COUNT_LOW, 8'hF0);
		n = txPulses;
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h14);
		repeat (40) @(negedge clock);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[7], 1'b0)
		`CHK(txPulses - n, 1)
		`CHK(clockOutData, 4'h0)
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h00);
	endtask
	task automatic t_split;
		wr(2'h0, `TMR2_ADDR_RELOAD_LOW, 8'h20);
		wr(2'h0, `TMR2_ADDR_COUNT_LOW, 8'hF0);
		wr(2'h0, `TMR2_ADDR_COUNT_HIGH, 8'h00);
		wr(2'h0, `TMR2_ADDR_MODE, 8'hC8);
		repeat (40) @(negedge clock);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h80);
		rd(2'h0, `TMR2_ADDR_COUNT_LOW, v);
		`CHK(v >= 8'h36 && v <= 8'h3C, 1'b1)
		rd(2'h0, `TMR2_ADDR_COUNT_HIGH, w);
		`CHK(w, 8'h00)
		repeat (10) @(negedge clock);
		rd(2'h0, `TMR2_ADDR_COUNT_LOW, w);
		`CHK(w, v)
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h20);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[5], 1'b1)
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h00);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h00);
	endtask
	task automatic t_clkout;
		for (int i = 0; i < 4; i++) begin
			wr(2'h1, `TMR2_ADDR_PIN_SEL, {i[1:0], 6'h3F});
			rd(2'h1, `TMR2_ADDR_PIN_SEL, v);
			`CHK(v, {i[1:0], 6'h00})
			wr(2'h0, `TMR2_ADDR_MODE, 8'h02);
			repeat (3) @(negedge clock);
			`CHK(clockOutOe, 4'h1 << i)
			wr(2'h0, `TMR2_ADDR_MODE, 8'h00);
			repeat (3) @(negedge clock);
			`CHK(clockOutOe, 4'h0)
		end
		wr(2'h1, `TMR2_ADDR_PIN_SEL, 8'h00);
	endtask
	task automatic t_trigger;
		wr(2'h0, `TMR2_ADDR_MODE, 8'h20);
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h01);
		pin[0] = 1'b1;
		repeat (8) @(negedge clock);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[6], 1'b1)
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h01);
		wr(2'h1, `TMR2_ADDR_MODE_EXT, 8'h20);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h60);
		pin[0] = 1'b0;
		repeat (8) @(negedge clock);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[6], 1'b1)
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h01);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h40);
		pin[0] = 1'b1;
		repeat (8) @(negedge clock);
		// inverted level now rises with rise enable off
		pin[0] = 1'b0;
		repeat (8) @(negedge clock);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[6], 1'b0)
		wr(2'h1, `TMR2_ADDR_PIN_SEL, 8'hC0);
		wr(2'h0, `TMR2_ADDR_MODE, 8'h20);
		wr(2'h0, `TMR2_ADDR_CONTROL, 8'h01);
		pin[3] = 1'b1;
		repeat (8) @(negedge clock);
		rd(2'h0, `TMR2_ADDR_CONTROL, v);
		`CHK(v[6], 1'b1)
	endtask
	initial begin
		rst_n = 1'b0;
		sfrWrite = 1'b0;
		sfrPage = 2'h0;
		sfrAddr = 8'h00;
		sfrWdata = 8'h00;
		ev = 10'h000;
		pin = 6'h00;
		repeat (5) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		t_reset();
		t_regs();
		t_alias();
		t_count();
		t_split();
		t_clkout();
		t_trigger();
		stop_test();
	end
endmodule // tmr2_core_test
